// ---- rtl/cre_pkg.sv ----
package cre_pkg;
   // status word fields
   localparam int          SR_T1      = 15;
   localparam int          SR_T0      = 14;
   localparam int          SR_S       = 13;
   localparam int          SR_M       = 12;
   localparam int          SR_IPM_LO  = 8;
   localparam logic [2:0]  IPM_TOP    = 3'h7;
   localparam logic [15:0] SR_RST     = 16'h2700;
   localparam logic [31:0] VBR_RST    = 32'h0000_0000;
   // control register enable and page bits
   localparam int          CACHE_CONTROL_WORD_DE    = 31;
   localparam int          CACHE_CONTROL_WORD_IE    = 15;
   localparam int          TC_E       = 15;
   localparam int          TC_P       = 14;
   localparam int          TT_E       = 15;
   // reset vector fetch
   localparam logic [31:0] VEC_ISP_ADDR = 32'h0000_0000;
   localparam logic [31:0] VEC_PC_ADDR  = 32'h0000_0004;
   localparam logic [31:0] LONG_STEP    = 32'h0000_0004;
   localparam logic [1:0]  PF_LAST      = 2'h3;
   // processor state codes
   localparam logic [3:0]  PST_NORM   = 4'h0;
   localparam logic [3:0]  PST_HALT   = 4'h5;
   // reset-out pulse
   localparam int          CLK_PERIOD_NS  = 50;
   localparam int          RST_OUT_NS     = 10000;
   localparam int          RST_OUT_CYC    = RST_OUT_NS / CLK_PERIOD_NS;
   // exception groups, bit index of the pending vector
   localparam int          G_DACC   = 1;
   localparam int          G_FPPRE  = 2;
   localparam int          G_INSN   = 3;
   localparam int          G_FPPOST = 4;
   localparam int          G_ADDR   = 5;
   localparam int          G_TRACE  = 6;
   localparam int          G_IACC   = 7;
   localparam int          G_INT    = 8;
   // frame formats and access frame flags
   localparam logic [3:0]  FMT_FOUR   = 4'h0;
   localparam logic [3:0]  FMT_THROW  = 4'h1;
   localparam logic [3:0]  FMT_SIX    = 4'h2;
   localparam logic [3:0]  FMT_FPPOST = 4'h3;
   localparam logic [3:0]  FMT_ACC    = 4'h7;
   localparam int          FLG_TRACE  = 2;
   localparam int          FLG_FPPOST = 1;
   localparam int          FLG_FPUNIM = 0;
   // register indices
   localparam logic [3:0]  REG_SR   = 4'h0;
   localparam logic [3:0]  REG_VBR  = 4'h1;
   localparam logic [3:0]  REG_CACHE_CONTROL_WORD = 4'h2;
   localparam logic [3:0]  REG_TC   = 4'h3;
   localparam logic [3:0]  REG_TT0  = 4'h4;
   localparam logic [3:0]  REG_ISP  = 4'h8;
   localparam logic [3:0]  REG_PC   = 4'h9;
   localparam logic [3:0]  REG_STAT = 4'ha;

   typedef enum logic [2:0] {
      S_RESET = 3'b000, S_IACK = 3'b001, S_VEC0 = 3'b011, S_VEC1 = 3'b010,
      S_PREF  = 3'b110, S_RUN  = 3'b111, S_HALT = 3'b101
   } cre_state_t;

   typedef enum logic [2:0] {
      RTE_NONE = 3'h0, RTE_RESTORE = 3'h1, RTE_AGAIN = 3'h2,
      RTE_CONVERT = 3'h3, RTE_FMTERR = 3'h4, RTE_ADDRERR = 3'h5
   } cre_rte_t;
endpackage : cre_pkg

// ---- rtl/cre_prio.sv ----
`timescale 1ns/1ps
module cre_prio
   import cre_pkg::*;
(
   input  wire logic [8:1] pend_in,    // pending groups 1..8
   input  wire logic       float_move_op_in,   // last op was a float_move_op to memory
   output logic      [8:1] grant_out   // one-hot winner
);
   logic [8:1] eff;

   function automatic logic [8:1] first_set(input logic [8:1] v);
      logic [8:1] g;
      g = 8'h00;
      for (int i = 8; i >= 1; i--) begin
         if (v[i]) begin
            g = 8'h00;
            g[i] = 1'b1;
         end
      end
      return g;
   endfunction : first_set

   always_comb begin
      eff = pend_in;
      eff[G_FPPOST] = pend_in[G_FPPOST] & float_move_op_in;
      // the other handler checks for trace itself
      if (pend_in[G_INSN] || eff[G_FPPOST]) begin
         eff[G_TRACE] = 1'b0;
      end
      grant_out = first_set(eff);
   end
endmodule : cre_prio

// ---- rtl/cre_exc_unit.sv ----
`timescale 1ns/1ps
module cre_exc_unit
   import cre_pkg::*;
#(
   parameter int RST_CYC = RST_OUT_CYC
) (
   input  wire logic           CLK_IN,            // 20 MHz clock
   input  wire logic           RESETN_IN,         // async reset, low
   input  wire logic [3:0]     REG_ADDR_IN,       // register index
   input  wire logic [31:0]    REG_WDATA_IN,      // write data
   input  wire logic           REG_WR_IN,         // write strobe
   input  wire logic           REG_RD_IN,         // read strobe
   output logic      [31:0]    REG_RDATA_OUT,     // read data, next cycle
   output logic                BUS_REQ_OUT,       // bus cycle request
   output logic                BUS_IACK_OUT,      // acknowledge cycle
   output logic                BUS_SUPER_OUT,     // supervisor space
   output logic                BUS_LONG_OUT,      // long word transfer
   output logic      [31:0]    BUS_ADDR_OUT,      // bus address
   input  wire logic           BUS_ACK_IN,        // cycle done
   input  wire logic           BUS_ERR_IN,        // access fault
   input  wire logic [31:0]    BUS_DATA_IN,       // read data
   output logic      [3:0]     PST_OUT,           // processor_state_lines
   output logic                RESET_OUT_LINE_OUT, // reset_out_line
   input  wire logic           SWRESET_IN,        // software reset op
   input  wire logic [8:1]     EXC_PEND_IN,       // pending groups
   input  wire logic           FLOAT_MOVE_OP_IN,          // float_move_op to memory
   input  wire logic           FP_UNIMP_IN,       // unimplemented float
   input  wire logic           EXC_DONE_IN,       // processing finished
   input  wire logic [7:0]     EXC_VECNUM_IN,     // vector of finished one
   output logic      [8:1]     EXC_GRANT_OUT,     // group being processed
   output logic      [2:0]     FRAME_FLAGS_OUT,   // access frame flags
   output logic                RESUME_OUT,        // resume pulse
   output logic      [31:0]    RESUME_ADDR_OUT,   // resume address
   input  wire logic           RTE_REQ_IN,        // return op issued
   input  wire logic [3:0]     RTE_FMT_IN,        // stacked format
   input  wire logic [15:0]    RTE_SR_IN,         // stacked status word
   input  wire logic [31:0]    RTE_PC_IN,         // stacked PC
   input  wire logic [2:0]     RTE_FLAGS_IN,      // special_status_word flags
   output cre_pkg::cre_rte_t   RTE_RESULT_OUT,    // restoration chosen
   output logic      [3:0]     RTE_NEWFMT_OUT,    // converted format
   output logic      [15:0]    RTE_SR_OUT         // status word to stack
);
   import cre_pkg::*;

   localparam logic [7:0] RST_LOAD = 8'(RST_CYC - 1);

   typedef struct packed {
      cre_state_t st;
      logic [1:0]  pf_cnt;
      logic [15:0] sr;
      logic [31:0] vector_base_pointer;
      logic [1:0]  cache_en;
      logic        tc_en;
      logic [3:0]  tt_en;
      logic [31:0] isp;
      logic [31:0] pc;
      logic        bus_req;
      logic        bus_iack;
      logic [31:0] bus_addr;
      logic [31:0] rdata;
      logic        rst_out;
      logic [7:0]  rst_cnt;
      logic [3:0]  pst;
      logic [8:1]  grant;
      logic        busy;
      logic [2:0]  flags;
      logic        resume;
      logic [31:0] resume_addr;
      cre_rte_t    rte_res;
      logic [3:0]  rte_fmt;
      logic [15:0] rte_sr;
   } cre_state_s_t;

   cre_state_s_t r;
   cre_state_s_t next_r;
   logic         tc_page;
   logic [8:1]   grant_w;
   logic         fp_pend;

   function automatic logic [31:0] reg_read(input cre_state_s_t s,
                                            input logic pg,
                                            input logic [3:0] a);
      logic [31:0] d;
      d = 32'h0;
      unique case (a)
         REG_SR:   d = {16'h0, s.sr};
         REG_VBR:  d = s.vector_base_pointer;
         REG_CACHE_CONTROL_WORD: begin
            d[CACHE_CONTROL_WORD_DE] = s.cache_en[1];
            d[CACHE_CONTROL_WORD_IE] = s.cache_en[0];
         end
         REG_TC:   begin
            d[TC_E] = s.tc_en;
            d[TC_P] = pg;
         end
         REG_ISP:  d = s.isp;
         REG_PC:   d = s.pc;
         REG_STAT: d = {20'h0, s.pst, s.busy, s.rst_out, 3'(s.st)};
         default: begin
            if (a[3:2] == REG_TT0[3:2]) begin
               d[TT_E] = s.tt_en[a[1:0]];
            end
         end
      endcase
      return d;
   endfunction : reg_read

   cre_prio u_prio (
      .pend_in   (EXC_PEND_IN),
      .float_move_op_in  (FLOAT_MOVE_OP_IN),
      .grant_out (grant_w)
   );

   assign fp_pend = (EXC_PEND_IN[G_FPPOST] & FLOAT_MOVE_OP_IN) | FP_UNIMP_IN;

   always_comb begin
      next_r = r;
      next_r.resume  = 1'b0;
      next_r.rte_res = RTE_NONE;
      next_r.rdata   = 32'h0;
      // software reset: external line only, no internal state touched
      if (r.st == S_RUN && SWRESET_IN) begin
         next_r.rst_out = 1'b1;
         next_r.rst_cnt = RST_LOAD;
      end else if (r.rst_out) begin
         if (r.rst_cnt == 8'h0) begin
            next_r.rst_out = 1'b0;
         end else begin
            next_r.rst_cnt = r.rst_cnt - 8'h1;
         end
      end
      unique case (r.st)
         S_RESET: begin
            next_r.st       = S_IACK;
            next_r.bus_req  = 1'b1;
            next_r.bus_iack = 1'b1;
            next_r.bus_addr = VEC_ISP_ADDR;
         end
         S_IACK: begin
            if (BUS_ACK_IN) begin
               next_r.bus_iack = 1'b0;
               next_r.bus_addr = VEC_ISP_ADDR;
               next_r.st       = S_VEC0;
            end
         end
         S_VEC0: begin
            if (BUS_ACK_IN) begin
               next_r.isp      = BUS_DATA_IN;
               next_r.bus_addr = VEC_PC_ADDR;
               next_r.st       = S_VEC1;
            end
         end
         S_VEC1: begin
            if (BUS_ACK_IN) begin
               next_r.pc       = BUS_DATA_IN;
               next_r.bus_addr = BUS_DATA_IN;
               next_r.pf_cnt   = 2'h0;
               next_r.st       = S_PREF;
            end
         end
         S_PREF: begin
            if (BUS_ACK_IN) begin
               if (r.pf_cnt == PF_LAST) begin
                  next_r.bus_req = 1'b0;
                  next_r.st      = S_RUN;
               end else begin
                  next_r.pf_cnt   = r.pf_cnt + 2'h1;
                  next_r.bus_addr = r.bus_addr + LONG_STEP;
               end
            end
         end
         S_RUN: begin
            if (!r.busy && |grant_w) begin
               next_r.grant = grant_w;
               next_r.busy  = 1'b1;
               if (grant_w[G_DACC]) begin
                  // trace left low when a float one is flagged
                  next_r.flags[FLG_TRACE] = EXC_PEND_IN[G_TRACE] &
                                            ~fp_pend;
                  next_r.flags[FLG_FPPOST] = EXC_PEND_IN[G_FPPOST] &
                                             FLOAT_MOVE_OP_IN;
                  next_r.flags[FLG_FPUNIM] = FP_UNIMP_IN & ~FLOAT_MOVE_OP_IN;
               end
            end else if (r.busy && EXC_DONE_IN) begin
               if (EXC_PEND_IN[G_INT] && !r.grant[G_INT]) begin
                  next_r.grant = 8'h80;
               end else begin
                  next_r.busy        = 1'b0;
                  next_r.grant       = 8'h00;
                  next_r.resume      = 1'b1;
                  next_r.resume_addr = r.vector_base_pointer +
                                       {22'h0, EXC_VECNUM_IN, 2'h0};
               end
            end else if (!r.busy && RTE_REQ_IN) begin
               next_r.rte_sr  = RTE_SR_IN;
               next_r.rte_fmt = RTE_FMT_IN;
               unique case (RTE_FMT_IN)
                  FMT_FOUR, FMT_SIX, FMT_FPPOST:
                     next_r.rte_res = RTE_RESTORE;
                  FMT_THROW: begin
                     next_r.rte_res = RTE_AGAIN;
                     next_r.sr      = RTE_SR_IN;
                  end
                  FMT_ACC: begin
                     if (RTE_FLAGS_IN[FLG_FPPOST]) begin
                        next_r.rte_res = RTE_CONVERT;
                        next_r.rte_fmt = FMT_FPPOST;
                     end else if (|RTE_FLAGS_IN) begin
                        next_r.rte_res = RTE_CONVERT;
                        next_r.rte_fmt = FMT_SIX;
                     end else begin
                        next_r.rte_res = RTE_RESTORE;
                     end
                  end
                  default: next_r.rte_res = RTE_FMTERR;
               endcase
               if (next_r.rte_res == RTE_RESTORE) begin
                  if (RTE_PC_IN[0] && RTE_SR_IN[SR_T1] && !RTE_SR_IN[SR_S]) begin
                     next_r.rte_res       = RTE_ADDRERR;
                     next_r.rte_sr[SR_S]  = 1'b1;
                  end else begin
                     next_r.sr = RTE_SR_IN;
                     next_r.pc = RTE_PC_IN;
                  end
               end
            end
         end
         S_HALT: next_r.bus_req = 1'b0;
      endcase
      // any fault while fetching for reset is a double fault
      if (r.bus_req && BUS_ERR_IN && r.st != S_RUN) begin
         next_r.st      = S_HALT;
         next_r.bus_req = 1'b0;
         next_r.pst     = PST_HALT;
      end else if (r.st == S_VEC1 && BUS_ACK_IN && BUS_DATA_IN[0]) begin
         next_r.st      = S_HALT;
         next_r.bus_req = 1'b0;
         next_r.pst     = PST_HALT;
      end
      if (REG_WR_IN) begin
         unique case (REG_ADDR_IN)
            REG_SR:   next_r.sr  = REG_WDATA_IN[15:0];
            REG_VBR:  next_r.vector_base_pointer = REG_WDATA_IN;
            REG_CACHE_CONTROL_WORD: next_r.cache_en = {REG_WDATA_IN[CACHE_CONTROL_WORD_DE],
                                         REG_WDATA_IN[CACHE_CONTROL_WORD_IE]};
            REG_TC:   next_r.tc_en = REG_WDATA_IN[TC_E];
            default: begin
               if (REG_ADDR_IN[3:2] == REG_TT0[3:2]) begin
                  next_r.tt_en[REG_ADDR_IN[1:0]] = REG_WDATA_IN[TT_E];
               end
            end
         endcase
      end
      if (REG_RD_IN) begin
         next_r.rdata = reg_read(r, tc_page, REG_ADDR_IN);
      end
   end

   // reset aborts everything and drops all pending work; nothing is stacked
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         r          <= '0;
         r.st       <= S_RESET;
         r.sr       <= SR_RST;
         r.vector_base_pointer      <= VBR_RST;
         r.cache_en <= 2'h0;
         r.tc_en    <= 1'b0;
         r.tt_en    <= 4'h0;
         r.pst      <= PST_NORM;
         r.rte_res  <= RTE_NONE;
      end else begin
         r <= next_r;
      end
   end

   // page size survives reset, so this flop has no reset term
   always_ff @(posedge CLK_IN) begin
      if (REG_WR_IN && REG_ADDR_IN == REG_TC) begin
         tc_page <= REG_WDATA_IN[TC_P];
      end
   end

   assign REG_RDATA_OUT      = r.rdata;
   assign BUS_REQ_OUT        = r.bus_req;
   assign BUS_IACK_OUT       = r.bus_iack;
   assign BUS_SUPER_OUT      = r.sr[SR_S];
   assign BUS_LONG_OUT       = r.bus_req;
   assign BUS_ADDR_OUT       = r.bus_addr;
   assign PST_OUT            = r.pst;
   assign RESET_OUT_LINE_OUT = r.rst_out;
   assign EXC_GRANT_OUT      = r.grant;
   assign FRAME_FLAGS_OUT    = r.flags;
   assign RESUME_OUT         = r.resume;
   assign RESUME_ADDR_OUT    = r.resume_addr;
   assign RTE_RESULT_OUT     = r.rte_res;
   assign RTE_NEWFMT_OUT     = r.rte_fmt;
   assign RTE_SR_OUT         = r.rte_sr;

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   sequence s_reset_seen;
      r.st == S_RESET;
   endsequence
   sequence s_fetch_err;
      r.bus_req && BUS_ERR_IN && r.st != S_RUN;
   endsequence

   AST_SEQ_START: assert property (s_reset_seen |=> BUS_REQ_OUT &&
      BUS_IACK_OUT && BUS_ADDR_OUT == VEC_ISP_ADDR)
      else $error("reset sequence did not start with acknowledge");
   AST_SR_RESET: assert property (s_reset_seen |-> r.sr == SR_RST &&
      !BUS_REQ_OUT)
      else $error("status word wrong after reset");
   AST_CTRL_RESET: assert property (s_reset_seen |-> r.vector_base_pointer == VBR_RST &&
      r.cache_en == 2'h0 && !r.tc_en && r.tt_en == 4'h0)
      else $error("control enables not cleared by reset");
   AST_ISP_LOAD: assert property (r.st == S_VEC0 && BUS_ACK_IN &&
      !BUS_ERR_IN |=> r.isp == $past(BUS_DATA_IN) &&
      BUS_ADDR_OUT == VEC_PC_ADDR)
      else $error("stack pointer vector not loaded");
   AST_PREFETCH: assert property (r.st == S_PREF && BUS_ACK_IN &&
      !BUS_ERR_IN && r.pf_cnt != PF_LAST |=>
      BUS_ADDR_OUT == $past(BUS_ADDR_OUT) + LONG_STEP)
      else $error("prefetch address did not step");
   AST_DOUBLE_FAULT: assert property (s_fetch_err |=>
      (PST_OUT == PST_HALT && !BUS_REQ_OUT)[*4])
      else $error("fault during reset did not halt");
   AST_SW_RESET: assert property (r.st == S_RUN && SWRESET_IN |=>
      RESET_OUT_LINE_OUT && r.st == S_RUN)
      else $error("software reset misbehaved");
   AST_DACC_FIRST: assert property (r.st == S_RUN && !r.busy &&
      EXC_PEND_IN[G_DACC] |=> EXC_GRANT_OUT == 8'h01)
      else $error("data access error not granted first");
   AST_TRACE_HIDE: assert property (r.st == S_RUN && !r.busy &&
      EXC_PEND_IN[G_TRACE] && EXC_PEND_IN[G_INSN] &&
      EXC_PEND_IN[2:1] == 2'h0 |=> EXC_GRANT_OUT[G_INSN])
      else $error("trace not suppressed");
   AST_INT_NEXT: assert property (r.busy && EXC_DONE_IN &&
      EXC_PEND_IN[G_INT] && !r.grant[G_INT] |=>
      EXC_GRANT_OUT == 8'h80 && !RESUME_OUT)
      else $error("pending interrupt not taken next");
   AST_RTE_ADDR: assert property (RTE_RESULT_OUT == RTE_ADDRERR |->
      RTE_SR_OUT[SR_S])
      else $error("address error frame lacks supervisor bit");
   AST_RD_ONCE: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
      else $error("read data outside its cycle");
endmodule : cre_exc_unit

// ---- bench/cre_mem_model.sv ----
`timescale 1ns/1ps
module cre_mem_model #(
   parameter logic [31:0] ISP_VAL = 32'h0000_8000,
   parameter logic [31:0] PC_VAL  = 32'h0000_0100
) (
   input  wire logic        clk_in,      // clock
   input  wire logic        rstn_in,     // reset, low
   input  wire logic        req_in,      // cycle request
   input  wire logic        iack_in,     // acknowledge cycle
   input  wire logic        super_in,    // supervisor space
   input  wire logic        long_in,     // long transfer
   input  wire logic [31:0] addr_in,     // address
   input  wire logic [3:0]  fault_idx_in, // cycle to fault, f none
   input  wire logic        slow_in,     // answer only every third cycle
   output logic             ack_out,     // cycle done
   output logic             err_out,     // access fault
   output logic [31:0]      data_out     // read data
);
   int          n;
   logic        ph;
   logic [33:0] log_q [0:7];
   // data never holds its last value between answers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_out  <= 1'b0;
         err_out  <= 1'b0;
         n        <= 0;
         ph       <= 1'b0;
         data_out <= 32'h5a5a_a5a5;
      end else if (req_in && !ack_out && !err_out && (!slow_in || ph)) begin
         if (n == int'(fault_idx_in)) err_out <= 1'b1;
         else ack_out <= 1'b1;
         log_q[n[2:0]] <= {super_in, long_in, addr_in};
         n             <= n + 1;
         data_out <= iack_in ? 32'h0000_0018 : (addr_in == 32'h0) ? ISP_VAL :
                     (addr_in == 32'h4) ? PC_VAL : ~addr_in;
      end else begin
         ack_out  <= 1'b0;
         err_out  <= 1'b0;
         ph       <= ~ph;
         data_out <= ~data_out;
      end
   end
endmodule : cre_mem_model

// ---- bench/cre_exc_unit_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module cre_exc_unit_test;
   import cre_pkg::*;
   localparam logic [31:0] PCV = 32'h0000_0100;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, swr = 1'b0;
   logic done = 1'b0, return_from_exception_op = 1'b0, fm = 1'b0, fpu = 1'b0, slow = 1'b0;
   logic ack, err, req, iack, sup, lng, rso, res;
   logic [3:0] ra = 4'h0, rfmt = 4'h0, fidx = 4'hf, pst, nfmt;
   logic [31:0] wd = 32'h0, rpc = 32'h0, rdat, bd, ba, raddr, d;
   logic [8:1] pend = 8'h0, gnt;
   logic [7:0] vec = 8'h0;
   logic [2:0] rfl = 3'h0, flg;
   logic [15:0] rsr = 16'h0, sro;
   cre_rte_t rres;
   int n_mismatch = 0, compares = 0, cyc = 0, i, k;

   always #25 clk = ~clk;

   cre_exc_unit #(.RST_CYC(4)) dut (.CLK_IN(clk), .RESETN_IN(rstn),
      .REG_ADDR_IN(ra), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdat), .BUS_REQ_OUT(req), .BUS_IACK_OUT(iack),
      .BUS_SUPER_OUT(sup), .BUS_LONG_OUT(lng), .BUS_ADDR_OUT(ba),
      .BUS_ACK_IN(ack), .BUS_ERR_IN(err), .BUS_DATA_IN(bd), .PST_OUT(pst),
      .RESET_OUT_LINE_OUT(rso), .SWRESET_IN(swr), .EXC_PEND_IN(pend),
      .FLOAT_MOVE_OP_IN(fm), .FP_UNIMP_IN(fpu), .EXC_DONE_IN(done),
      .EXC_VECNUM_IN(vec), .EXC_GRANT_OUT(gnt), .FRAME_FLAGS_OUT(flg),
      .RESUME_OUT(res), .RESUME_ADDR_OUT(raddr), .RTE_REQ_IN(return_from_exception_op),
      .RTE_FMT_IN(rfmt), .RTE_SR_IN(rsr), .RTE_PC_IN(rpc),
      .RTE_FLAGS_IN(rfl), .RTE_RESULT_OUT(rres), .RTE_NEWFMT_OUT(nfmt),
      .RTE_SR_OUT(sro));
   cre_mem_model #(.PC_VAL(PCV)) mem (.clk_in(clk), .rstn_in(rstn),
      .req_in(req), .iack_in(iack), .super_in(sup), .long_in(lng),
      .addr_in(ba), .fault_idx_in(fidx), .slow_in(slow), .ack_out(ack),
      .err_out(err), .data_out(bd));

   task stop_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk); ra <= a; wd <= v; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask : wreg

   task rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk); ra <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      @(negedge clk); `CHK(rdat & m, e)
   endtask : rchk

   task do_reset;
      @(posedge clk); rstn <= 1'b0; pend <= 8'h0;
      repeat (20) @(posedge clk);
      @(negedge clk); `CHK({req, gnt, pst}, 13'h0)
      @(posedge clk); rstn <= 1'b1;
      @(posedge clk);
      @(negedge clk); `CHK({req, iack, ba}, {2'b11, 32'h0})
   endtask : do_reset

   task wait_fetch;
      i = 0;
      while (mem.n != 7 && i < 80) begin
         @(posedge clk); i++;
      end
      repeat (2) @(posedge clk);
      @(negedge clk); `CHK({req, gnt}, 9'h0)
   endtask : wait_fetch

   task take(input logic [8:1] p, input logic f, input logic [8:1] g);
      @(posedge clk); pend <= p; fm <= f;
      @(posedge clk);
      @(negedge clk); `CHK(gnt, g)
   endtask : take

   task fin(input logic [7:0] v, input logic [8:1] p, input logic r);
      @(posedge clk); done <= 1'b1; vec <= v; pend <= p;
      @(posedge clk); done <= 1'b0;
      @(negedge clk); `CHK(res, r)
      if (r) `CHK(raddr, 32'h1000 + {22'h0, v, 2'b00})
   endtask : fin

   task rtet(input logic [3:0] f, input logic [15:0] s, input logic [31:0] pc,
             input logic [2:0] fl, input cre_rte_t r, input logic [3:0] nf);
      @(posedge clk); rfmt <= f; rsr <= s; rpc <= pc; rfl <= fl; return_from_exception_op <= 1'b1;
      @(posedge clk); return_from_exception_op <= 1'b0;
      @(negedge clk); `CHK(rres, r)
      if (r == RTE_CONVERT) `CHK(nfmt, nf)
      if (r == RTE_ADDRERR) `CHK(sro[SR_S], 1'b1)
   endtask : rtet

   initial begin
      do_reset();
      wait_fetch();
      for (k = 0; k < 7; k++) begin
         d = (k == 2) ? 32'h4 : ((k < 3) ? 32'h0 : PCV + 32'(4 * (k - 3)));
         `CHK(mem.log_q[k], {2'b11, d})
      end
      rchk(REG_ISP, 32'hffff_ffff, 32'h0000_8000);
      rchk(REG_PC, 32'hffff_ffff, PCV);
      rchk(4'hb, 32'hffff_ffff, 32'h0);
      // dirty every enable, then reset in the middle of a grant
      wreg(REG_VBR, 32'h1000);
      wreg(REG_CACHE_CONTROL_WORD, 32'hffff_ffff);
      wreg(REG_TC, 32'h0000_c000);
      for (k = 4; k < 8; k++) wreg(k[3:0], 32'h8000);
      take(8'h01, 1'b0, 8'h01);
      slow <= 1'b1;
      do_reset();
      wait_fetch();
      slow <= 1'b0;
      rchk(REG_SR, 32'hffff, 32'h2700);
      rchk(REG_VBR, 32'hffff_ffff, VBR_RST);
      rchk(REG_CACHE_CONTROL_WORD, 32'h8000_8000, 32'h0);
      rchk(REG_TC, 32'hc000, 32'h4000);
      for (k = 4; k < 8; k++) rchk(k[3:0], 32'h8000, 32'h0);
      fidx <= 4'h2;
      do_reset();
      repeat (10) @(posedge clk);
      @(negedge clk); `CHK({pst, req}, {PST_HALT, 1'b0})
      fidx <= 4'hf;
      do_reset();
      wait_fetch();
      wreg(REG_SR, 32'h2300);
      @(posedge clk); swr <= 1'b1;
      @(posedge clk); swr <= 1'b0;
      k = 0;
      repeat (12) begin
         @(negedge clk);
         if (rso === 1'b1) k++;
      end
      `CHK(k, 4)
      rchk(REG_SR, 32'hffff, 32'h2300);
      wreg(REG_VBR, 32'h1000);
      for (k = 1; k <= 8; k++) begin
         take(8'hff << (k - 1), 1'b1, 8'h01 << (k - 1));
         fin(8'(k + 8), 8'h0, 1'b1);
      end
      take(8'h28, 1'b0, 8'h20);
      fin(8'h09, 8'h0, 1'b1);
      take(8'h84, 1'b1, 8'h04);
      fin(8'h0b, 8'h80, 1'b0);
      `CHK(gnt, 8'h80)
      fin(8'h19, 8'h0, 1'b1);
      take(8'h29, 1'b1, 8'h01);
      `CHK(flg, 3'b010)
      fin(8'h02, 8'h0, 1'b1);
      rtet(FMT_FOUR, 16'h8000, 32'h101, 3'h0, RTE_ADDRERR, 4'h0);
      rtet(FMT_FOUR, 16'h2000, 32'h100, 3'h0, RTE_RESTORE, 4'h0);
      rtet(FMT_THROW, 16'h2000, 32'h100, 3'h0, RTE_AGAIN, 4'h0);
      rtet(FMT_ACC, 16'h2000, 32'h100, 3'h2, RTE_CONVERT, FMT_FPPOST);
      rtet(FMT_ACC, 16'h2000, 32'h100, 3'h4, RTE_CONVERT, FMT_SIX);
      rtet(4'hf, 16'h2000, 32'h100, 3'h0, RTE_FMTERR, 4'h0);
      stop_test();
   end
endmodule : cre_exc_unit_test
